// File: adrs_defs.vh
`ifndef ADRS_DEFS_VH
`define ADRS_DEFS_VH
// Register offset of the status view
`define ADRS_STATUS_ADDR   7'h00
`define ADRS_ADDR_W        7
// FIFO output mode value that selects the data-ready view
`define ADRS_FMODE_OFF     2'h0
// Field positions of the data-ready view
`define ADRS_BIT_XDR       0
`define ADRS_BIT_YDR       1
`define ADRS_BIT_ZDR       2
`define ADRS_BIT_ZYXDR     3
`define ADRS_BIT_XOW       4
`define ADRS_BIT_YOW       5
`define ADRS_BIT_ZOW       6
`define ADRS_BIT_ZYXOW     7
// Reset value of the status register
`define ADRS_STATUS_RESET  8'h00
`endif

// File: adrs_axis_flags.v
`timescale 1ns/100ps
`default_nettype none
module adrs_axis_flags (
  input  wire clk,
  input  wire rstn,
  input  wire ce,
  input  wire acq_done,
  input  wire msb_read,
  output reg  ready,
  output reg  overwrite
);
  // Set wins over a clear in the same cycle so no sample event is lost
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ready     <= 1'b0;
      overwrite <= 1'b0;
    end else if (ce) begin
      if (acq_done)
        ready <= 1'b1;
      else if (msb_read)
        ready <= 1'b0;
      // Overwrite only when the previous value was still unread
      if (acq_done && ready && !msb_read)
        overwrite <= 1'b1;
      else if (msb_read)
        overwrite <= 1'b0;
    end
  end
endmodule // adrs_axis_flags
`default_nettype wire

// File: adrs_status.v
`timescale 1ns/100ps
`include "adrs_defs.vh"
`default_nettype none
module adrs_status (
  input  wire       clk,
  input  wire       rstn,
  input  wire       ce,
  input  wire [2:0] axis_enable,
  input  wire [2:0] acq_done,
  input  wire [2:0] msb_read,
  input  wire [1:0] fifo_mode,
  input  wire [7:0] fifo_status,
  input  wire       rd_en,
  input  wire [6:0] rd_addr,
  output reg  [7:0] rd_data,
  output wire       rd_hit,
  output wire [7:0] status
);
  wire [2:0] axis_ready;
  wire [2:0] axis_ow;
  wire [2:0] set_ev;
  reg        all_ready;
  reg        all_ow;
  reg  [2:0] pend_read;
  reg  [2:0] next_pend_read;
  wire [2:0] ov_ev;
  wire       set_done;
  wire       read_done;

  // Disabled axes cannot set flags; their high-byte reads still clear them
  assign set_ev = acq_done & axis_enable;

  // One flag pair per axis, x at index 0
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_axis
      adrs_axis_flags u_flags (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (ce),
        .acq_done  (set_ev[i]),
        .msb_read  (msb_read[i]),
        .ready     (axis_ready[i]),
        .overwrite (axis_ow[i])
      );
    end
  endgenerate

  // Unread replacement on any axis
  assign ov_ev = set_ev & axis_ready & ~msb_read;

  // Combined clear waits until every enabled high byte was read
  always @* begin
    next_pend_read = pend_read & ~msb_read;
    if (|set_ev)
      next_pend_read = axis_enable;
  end
  assign set_done  = |set_ev;
  assign read_done = (|pend_read) && ((pend_read & ~msb_read) == 3'h0);

  // Combined flags; a fresh sample wins over the final read
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      all_ready <= 1'b0;
      all_ow    <= 1'b0;
      pend_read <= 3'h0;
    end else if (ce) begin
      pend_read <= next_pend_read;
      if (set_done)
        all_ready <= 1'b1;
      else if (read_done)
        all_ready <= 1'b0;
      if (|ov_ev)
        all_ow <= 1'b1;
      else if (read_done)
        all_ow <= 1'b0;
    end
  end

  // Bit order of the data-ready view
  assign status = {all_ow, axis_ow[2], axis_ow[1], axis_ow[0],
                   all_ready, axis_ready[2], axis_ready[1], axis_ready[0]};

  assign rd_hit = rd_en && (rd_addr == `ADRS_STATUS_ADDR);

  // Registered read data; mode picks which view answers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= `ADRS_STATUS_RESET;
    end else if (ce && rd_en) begin
      if (rd_addr != `ADRS_STATUS_ADDR)
        rd_data <= 8'h00;
      else if (fifo_mode == `ADRS_FMODE_OFF)
        rd_data <= status;
      else
        rd_data <= fifo_status;
    end
  end
endmodule // adrs_status
`default_nettype wire

// File: adrs_status_sva.sv
`timescale 1ns/100ps
`default_nettype none
module adrs_status_chk(input wire clk,rstn,ce,rd_hit,input wire [2:0] axis_enable,acq_done,msb_read,
  input wire [1:0] fifo_mode,input wire [7:0] rd_data,status);
  // Samples that count: enabled axis, clock running
  wire [2:0] hit=acq_done&axis_enable&{3{ce}};
  default clocking @(posedge clk); endclocking
  default disable iff(!rstn);
  x_set_a:assert property(hit[0]|=>status[0])else $error("xdr");
  x_ow_a:assert property(hit[0]&&status[0]&&!msb_read[0]|=>status[4])else $error("xow");
  x_clr_a:assert property(ce&&msb_read[0]&&!acq_done[0]|=>!(status[0]|status[4]))else $error("xclr");
  all_clr_a:assert property(ce&&msb_read==3'h7&&!acq_done|=>!status)else $error("clr");
  sum_ow_a:assert property($rose(|status[6:4])|->status[7])else $error("ow");
  sum_set_a:assert property(|hit|=>status[3])else $error("dr");
  view_a:assert property(ce&&rd_hit&&!fifo_mode|=>rd_data==$past(status))else $error("view");
  hold_a:assert property(!ce|=>$stable(status))else $error("hold");
  cover property(status[7]);
  cover property(ce&&rd_hit&&fifo_mode);
  cover property($fell(status[3]));
endmodule // adrs_status_chk
bind adrs_status adrs_status_chk adrs_status_chk_i(.*);
`default_nettype wire

// File: adrs_status_bench.sv
`timescale 1ns/100ps
`default_nettype none
module adrs_status_bench;
  reg clk=0,rstn=0,ce=0,rd_en=0;
  reg [2:0] axis_enable=0,acq_done=0,msb_read=0,pend,a;
  reg [1:0] fifo_mode=0;
  reg [6:0] rd_addr=0;
  reg [7:0] fifo_status=0,m,q[$];
  wire [7:0] rd_data,status;
  wire rd_hit;
  integer seed=32'h36AFA8EE,errors=0,compares=0;
  adrs_status adrs_status_i(.*);
  initial forever #10 clk=~clk;
  task wrap_up;
    $display("errors %0d compares %0d",errors,compares);
    if(errors==0&&compares>0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input [55:0] w,input [7:0] e,s);
    compares++;
    if(e!==s) begin errors++; $display("unexpected %0s exp %h got %h",w,e,s); end
  endtask
  // Model notes each read; a sample beats a same-cycle read
  always @(posedge clk or negedge rstn)
    if(!rstn) {m,pend}<=0;
    else if(ce) begin
      a=acq_done&axis_enable;
      if(rd_en) q.push_back(rd_addr?8'h00:fifo_mode?fifo_status:m);
      m[6:4]<=(a&m[2:0]|m[6:4])&~msb_read;
      m[2:0]<=a|m[2:0]&~msb_read;
      pend<=a?axis_enable:pend&~msb_read;
      if(a) m[3]<=1;
      else if(pend&&!(pend&~msb_read)) m[3]<=0;
      if(a&m[2:0]&~msb_read) m[7]<=1;
      else if(pend&&!(pend&~msb_read)) m[7]<=0;
    end
  // Hit flag is combinational, so look once inputs have settled
  always @(posedge clk) if(rstn) chk("rd_hit",{7'h00,rd_en&&rd_addr==7'h00},{7'h00,rd_hit});
  // Outputs checked mid-cycle, once settled
  always @(negedge clk) if(rstn) begin
    chk("status",m,status);
    if(q.size()) chk("rd_data",q.pop_front(),rd_data);
  end
  // Random pulses, modes and enables; address kept to 0 or 1
  initial begin
    #60 rstn=1;
    repeat(5000) @(negedge clk) {fifo_status,fifo_mode,rd_addr[0],rd_en,msb_read,acq_done,axis_enable,ce}=$random(seed);
    $display("random test done");
    wrap_up;
  end
  initial begin #200000 errors++; wrap_up; end
endmodule // adrs_status_bench
`default_nettype wire
